// ---- hdl/exc_ctrl.sv ----
// Reset, interrupt arbitration, vectoring and stop/wait entry of an 8-bit core.
// Assumes one instruction-cycle clock; core pulses instr_done_i at each boundary.
`timescale 1ns/1ps

// Notes on behaviour
// - Hold reset for 1920 cycles after first clock activity.
// - If reset pin still low after the delay, stay in reset until released.
// - Reset clears timer request, sets timer mask, clears all direction bits.
// - Reset loads stack pointer with 007F.
// - Reset drives address bus to vector pair 1FFE/1FFF.
// - Reset sets I flag, clears stop/wait latches and external latch.
// - Reset leaves port latches and timer counter untouched.
// - Hardware interrupts wait for the current instruction to finish.
// - At boundary: I set means fetch; clear means service pending latch.
// - Interrupt entry pushes registers then sets the I flag.
// - Masked hardware interrupts stay latched until I clears.
// - External interrupt beats timer when both pending.
// - Vectors: external 1FFA, timer 1FF8, software trap 1FFC.
// - Timer taken in wait mode uses vector 1FF6/1FF7.
// - Unmasked timer raises request when counter goes 01 to 00.
// - External recognised when I clear and line low; edge or level option.
// - Level option: line still low after return raises another external interrupt.
// - Software trap enters regardless of the I flag.
// - Stop halts clock and timer, clears request, prescaler and I, sets mask.
// - Wait gates core clock, clears I; after external, timer uses normal vector.
// - Entry pushes five bytes, PC low first, SP decrementing.
module exc_ctrl #(
  parameter bit EDGE_ONLY = 1'b0
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        ext_irq_n_i,
  input  wire logic        instr_done_i,
  input  wire logic        trap_exec_i,
  input  wire logic        stop_exec_i,
  input  wire logic        wait_exec_i,
  input  wire logic        return_exec_i,
  input  wire logic        cli_exec_i,
  input  wire logic        sei_exec_i,
  input  wire logic        push_i,
  input  wire logic        pull_i,
  input  wire logic        timer_step_i,
  input  wire logic [7:0]  timer_count_i,
  input  wire logic        tcr_wr_i,
  input  wire logic [7:0]  tcr_wdata_i,
  input  wire logic        ddr_wr_i,
  input  wire logic [1:0]  ddr_sel_i,
  input  wire logic [7:0]  ddr_wdata_i,
  output logic             core_reset_o,
  output logic             core_clk_en_o,
  output logic             timer_clk_en_o,
  output logic             prescaler_clr_o,
  output logic             counter_load_o,
  output logic [7:0]       counter_load_val_o,
  output logic             enter_o,
  output logic [12:0]      vector_addr_o,
  output logic [12:0]      sp_o,
  output logic             i_flag_o,
  output logic             timer_request_flag_o,
  output logic             timer_irq_mask_o,
  output logic [31:0]      ddr_o,
  output logic             stop_o,
  output logic             wait_o
);
  // ****************
  // Pin synchronisers
  // ****************
  logic [1:0]  rst_sync_reg;
  logic [1:0]  irq_sync_reg;
  logic        irq_prev_reg;
  always_ff @(posedge sys_clk_i) begin
    rst_sync_reg <= {rst_sync_reg[0], reset_pin_n_i};
    irq_sync_reg <= {irq_sync_reg[0], ext_irq_n_i};
    irq_prev_reg <= irq_sync_reg[1];
  end
  logic rst_pin_low;
  logic irq_low;
  logic irq_fall;
  assign rst_pin_low = ~rst_sync_reg[1];
  assign irq_low     = ~irq_sync_reg[1];
  assign irq_fall    = irq_prev_reg & ~irq_sync_reg[1];

  // ****************
  // Power-on delay
  // ****************
  logic [10:0] por_cnt_reg;
  logic [10:0] por_cnt_next;
  logic        por_done_reg;
  logic        por_done_next;
  always_comb begin
    por_cnt_next  = por_cnt_reg;
    por_done_next = por_done_reg;
    if (!por_done_reg) begin
      if (por_cnt_reg == exc_ctrl_pkg::POR_CNT_LAST) begin
        por_done_next = 1'b1;
      end else begin
        por_cnt_next = por_cnt_reg + 11'h001;
      end
    end
  end
  // Power-up event is the system reset; count begins at its release
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
    end else begin
      por_cnt_reg  <= por_cnt_next;
      por_done_reg <= por_done_next;
    end
  end
  logic in_reset;
  // Pin held low past the delay keeps the core in reset
  assign in_reset = sys_rst_i | ~por_done_reg | rst_pin_low;

  // ****************
  // Control state
  // ****************
  typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_STOP, ST_WAIT} mode_e;
  mode_e       mode_reg, mode_next;
  logic        i_reg, i_next;
  logic        treq_reg, treq_next;
  logic        tmask_reg, tmask_next;
  logic        ext_latch_reg, ext_latch_next;
  logic [5:0]  sp_reg, sp_next;
  logic [2:0]  push_cnt_reg, push_cnt_next;
  logic [12:0] vec_reg, vec_next;
  logic        enter_next;
  logic        pclr_next;
  logic        load_next;
  logic        enter_reg, pclr_reg, load_reg;
  logic [31:0] ddr_reg, ddr_next;

  function automatic logic [12:0] timer_vec(input logic in_wait);
    timer_vec = in_wait ? exc_ctrl_pkg::VEC_TIMER_WAIT : exc_ctrl_pkg::VEC_TIMER;
  endfunction

  logic ext_pend;
  logic tim_pend;
  logic ext_set;
  always_comb begin
    mode_next      = mode_reg;
    i_next         = i_reg;
    treq_next      = treq_reg;
    tmask_next     = tmask_reg;
    ext_latch_next = ext_latch_reg;
    sp_next        = sp_reg;
    push_cnt_next  = push_cnt_reg;
    vec_next       = vec_reg;
    ddr_next       = ddr_reg;
    enter_next     = 1'b0;
    pclr_next      = 1'b0;
    load_next      = 1'b0;
    // Latch the external request; set wins over any clear this cycle
    ext_set = EDGE_ONLY ? irq_fall : (irq_fall | irq_low);
    if (ext_set) begin
      ext_latch_next = 1'b1;
    end
    if (tcr_wr_i) begin
      treq_next  = tcr_wdata_i[7];
      tmask_next = tcr_wdata_i[6];
      pclr_next  = tcr_wdata_i[3];
    end
    if (timer_step_i && timer_count_i == exc_ctrl_pkg::CNT_ONE) begin
      treq_next = 1'b1;
    end
    if (ddr_wr_i) begin
      ddr_next[ddr_sel_i*8 +: 8] = ddr_wdata_i;
    end
    if (cli_exec_i) begin
      i_next = 1'b0;
    end
    if (sei_exec_i) begin
      i_next = 1'b1;
    end
    if (push_i) begin
      sp_next = sp_reg - 6'h01;
    end else if (pull_i) begin
      sp_next = sp_reg + 6'h01;
    end
    if (return_exec_i) begin
      i_next = 1'b0;
    end
    ext_pend = ext_latch_next;
    tim_pend = treq_reg & ~tmask_reg;
    case (mode_reg)
      ST_RUN: begin
        // Decisions only at boundaries, never mid-instruction
        if (instr_done_i) begin
          if (stop_exec_i) begin
            mode_next  = ST_STOP;
            treq_next  = 1'b0;
            tmask_next = 1'b1;
            pclr_next  = 1'b1;
            load_next  = 1'b1;
            i_next     = 1'b0;
          end else if (wait_exec_i) begin
            mode_next = ST_WAIT;
            i_next    = 1'b0;
          end else if (trap_exec_i) begin
            vec_next      = exc_ctrl_pkg::VEC_SWTRAP;
            mode_next     = ST_PUSH;
            push_cnt_next = '0;
          end else if (!i_reg && ext_pend) begin
            vec_next       = exc_ctrl_pkg::VEC_EXT;
            ext_latch_next = ext_latch_reg & ext_set;
            mode_next      = ST_PUSH;
            push_cnt_next  = '0;
          end else if (!i_reg && tim_pend) begin
            vec_next      = timer_vec(1'b0);
            mode_next     = ST_PUSH;
            push_cnt_next = '0;
          end
        end
      end
      ST_PUSH: begin
        if (push_i) begin
          push_cnt_next = push_cnt_reg + 3'h1;
          if (push_cnt_reg == exc_ctrl_pkg::STACK_BYTES - 3'h1) begin
            i_next     = 1'b1;
            enter_next = 1'b1;
            mode_next  = ST_RUN;
          end
        end
      end
      ST_STOP: begin
        // Only the external line restarts the oscillator
        if (ext_pend) begin
          vec_next       = exc_ctrl_pkg::VEC_EXT;
          ext_latch_next = ext_latch_reg & ext_set;
          mode_next      = ST_PUSH;
          push_cnt_next  = '0;
        end
      end
      ST_WAIT: begin
        if (ext_pend) begin
          // Leaving wait here; a later timer uses the normal vector
          vec_next       = exc_ctrl_pkg::VEC_EXT;
          ext_latch_next = ext_latch_reg & ext_set;
          mode_next      = ST_PUSH;
          push_cnt_next  = '0;
        end else if (tim_pend) begin
          vec_next      = timer_vec(1'b1);
          mode_next     = ST_PUSH;
          push_cnt_next = '0;
        end
      end
      default: begin
        mode_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (in_reset) begin
      mode_reg      <= ST_RUN;
      i_reg         <= 1'b1;
      treq_reg      <= 1'b0;
      tmask_reg     <= 1'b1;
      ext_latch_reg <= 1'b0;
      sp_reg        <= exc_ctrl_pkg::SP_TOP[5:0];
      push_cnt_reg  <= '0;
      vec_reg       <= exc_ctrl_pkg::VEC_RESET;
      ddr_reg       <= {4{exc_ctrl_pkg::DDR_RESET}};
      enter_reg     <= 1'b0;
      pclr_reg      <= 1'b0;
      load_reg      <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      i_reg         <= i_next;
      treq_reg      <= treq_next;
      tmask_reg     <= tmask_next;
      ext_latch_reg <= ext_latch_next;
      sp_reg        <= sp_next;
      push_cnt_reg  <= push_cnt_next;
      vec_reg       <= vec_next;
      ddr_reg       <= ddr_next;
      enter_reg     <= enter_next;
      pclr_reg      <= pclr_next;
      load_reg      <= load_next;
    end
  end

  // ****************
  // Outputs
  // ****************
  // Port latches and counter live elsewhere and see no reset here
  assign core_reset_o         = in_reset;
  assign core_clk_en_o        = ~in_reset & (mode_reg == ST_RUN | mode_reg == ST_PUSH);
  assign timer_clk_en_o       = ~in_reset & (mode_reg != ST_STOP);
  assign prescaler_clr_o      = pclr_reg;
  assign counter_load_o       = load_reg;
  assign counter_load_val_o   = exc_ctrl_pkg::CNT_STOP_LOAD;
  assign enter_o              = enter_reg;
  assign vector_addr_o        = vec_reg;
  assign sp_o                 = {7'h01, sp_reg};
  assign i_flag_o             = i_reg;
  assign timer_request_flag_o = treq_reg;
  assign timer_irq_mask_o     = tmask_reg;
  assign ddr_o                = ddr_reg;
  assign stop_o               = (mode_reg == ST_STOP);
  assign wait_o               = (mode_reg == ST_WAIT);
endmodule

// ---- hdl/exc_ctrl_pkg.sv ----
// Constants for the reset, interrupt and low-power sequencer.
// Assumes a core that reports instruction boundaries and stack pushes.
package exc_ctrl_pkg;
  // ****************
  // Timing
  // ****************
  localparam int unsigned      POR_DELAY_CYC  = 1920;
  localparam logic [10:0]      POR_CNT_LAST   = 11'h77f;
  // ****************
  // Addresses, stack size and counter/port constants
  // ****************
  localparam logic [12:0]      SP_TOP         = 13'h007f;
  localparam logic [12:0]      VEC_RESET      = 13'h1ffe;
  localparam logic [12:0]      VEC_SWTRAP     = 13'h1ffc;
  localparam logic [12:0]      VEC_EXT        = 13'h1ffa;
  localparam logic [12:0]      VEC_TIMER      = 13'h1ff8;
  localparam logic [12:0]      VEC_TIMER_WAIT = 13'h1ff6;
  localparam logic [2:0]       STACK_BYTES    = 3'h5;
  localparam logic [7:0]       CNT_ONE        = 8'h01;
  localparam logic [7:0]       CNT_STOP_LOAD  = 8'hf0;
  localparam logic [7:0]       DDR_RESET      = 8'h00;
  // ****************
  // Vector sources
  // ****************
  typedef enum logic [1:0] {SRC_EXT, SRC_TIMER, SRC_TRAP} src_e;
endpackage

// ---- testbench/exc_ctrl_monitor.sv ----
// Port checker for the exception sequencer.
// Assumes one clock and the synchronous reset of the top module.
`timescale 1ns/1ps
module exc_ctrl_monitor (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        reset_pin_n_i,
  input wire logic        instr_done_i,
  input wire logic        trap_exec_i,
  input wire logic        stop_exec_i,
  input wire logic        push_i,
  input wire logic        timer_step_i,
  input wire logic [7:0]  timer_count_i,
  input wire logic        core_reset_o,
  input wire logic        core_clk_en_o,
  input wire logic        timer_clk_en_o,
  input wire logic        enter_o,
  input wire logic [12:0] vector_addr_o,
  input wire logic [12:0] sp_o,
  input wire logic        i_flag_o,
  input wire logic        timer_request_flag_o,
  input wire logic        timer_irq_mask_o,
  input wire logic [31:0] ddr_o,
  input wire logic        stop_o,
  input wire logic        wait_o
);
  // ****
  // Cycles since reset, saturating
  // ****
  logic [10:0] age_reg;
  logic [10:0] age_next;
  always_comb age_next = age_reg + {10'h0, age_reg != 11'h7ff};
  always_ff @(posedge sys_clk_i) age_reg <= sys_rst_i ? 11'h0 : age_next;
  default clocking mon_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Margin below 1920 so the exact release edge is left to the design
  por_hold_a: assert property (age_reg < 11'h76c |-> core_reset_o)
    else $error("core left reset early");
  pin_hold_a: assert property (!reset_pin_n_i [*3] |-> core_reset_o)
    else $error("core ran with pin low");
  rst_state_a: assert property ($fell(sys_rst_i) |-> i_flag_o && timer_irq_mask_o
    && !timer_request_flag_o && sp_o == 13'h007f && vector_addr_o == 13'h1ffe
    && ddr_o == 32'h0 && !stop_o && !wait_o) else $error("bad state after reset");
  trap_vec_a: assert property (instr_done_i && trap_exec_i && !core_reset_o
    |-> ##[1:2] vector_addr_o == 13'h1ffc) else $error("trap vector wrong");
  tmr_req_a: assert property (!core_reset_o && timer_step_i && !timer_irq_mask_o
    && timer_count_i == 8'h01 |-> ##[1:2] timer_request_flag_o) else $error("no timer request");
  enter_push_a: assert property (enter_o |-> $past(push_i))
    else $error("entry without push");
  enter_mask_a: assert property (enter_o |=> i_flag_o)
    else $error("mask clear after entry");
  sp_step_a: assert property (push_i && !core_reset_o |=> sp_o[12:6] == 7'h01
    && sp_o[5:0] == $past(sp_o[5:0]) - 6'h1) else $error("stack pointer step wrong");
  stop_entry_a: assert property (instr_done_i && stop_exec_i && !trap_exec_i && !core_reset_o
    |-> ##[1:2] (stop_o && !i_flag_o && timer_irq_mask_o && !timer_request_flag_o))
    else $error("stop entry state wrong");
  stop_gate_a: assert property (stop_o |-> !core_clk_en_o && !timer_clk_en_o)
    else $error("clocks run in stop");
  wait_gate_a: assert property (wait_o && !core_reset_o |-> !core_clk_en_o && timer_clk_en_o)
    else $error("clock gating wrong in wait");
endmodule

bind exc_ctrl exc_ctrl_monitor mon (.sys_clk_i, .sys_rst_i, .reset_pin_n_i, .instr_done_i,
  .trap_exec_i, .stop_exec_i, .push_i, .timer_step_i, .timer_count_i, .core_reset_o,
  .core_clk_en_o, .timer_clk_en_o, .enter_o, .vector_addr_o, .sp_o, .i_flag_o,
  .timer_request_flag_o, .timer_irq_mask_o, .ddr_o, .stop_o, .wait_o);

// ---- testbench/exc_src_model.sv ----
// Reset circuit and interrupt sources outside the sequencer.
// Assumes requests arrive from the bench at the falling edge.
`timescale 1ns/1ps
module exc_src_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_req_i,
  input  wire logic irq_pulse_i,
  input  wire logic irq_hold_i,
  output logic      reset_pin_n_o,
  output logic      ext_irq_n_o
);
  // ****
  // Line drivers, both lines pulled up
  // ****
  logic [1:0] pulse_reg = 2'h0;
  // Two cycles low so the synchroniser cannot miss it
  // Sampled on the rising edge, away from the bench's falling-edge drive
  always @(posedge sys_clk_i) pulse_reg <= irq_pulse_i ? 2'h3 : {1'b0, pulse_reg[1]};
  assign reset_pin_n_o = !rst_req_i;
  // Pulses spaced well past a handler; hold acts as wired-OR
  assign ext_irq_n_o = !(irq_hold_i || pulse_reg[0]);
endmodule

// ---- testbench/mcu_reset_interrupt_lowpower_ctrl_bench.sv ----
// Self-checking bench for the exception sequencer.
// Assumes the source model drives the reset pin and the interrupt line.
`timescale 1ns/1ps
module mcu_reset_interrupt_lowpower_ctrl_bench;
  logic        sys_clk_i, sys_rst_i, instr_done_i, trap_exec_i, stop_exec_i, wait_exec_i;
  logic        return_exec_i, cli_exec_i, sei_exec_i, push_i, pull_i, timer_step_i;
  logic        tcr_wr_i, ddr_wr_i, rst_req, irq_pulse, irq_hold, reset_pin_n_i, ext_irq_n_i;
  logic        core_reset_o, core_clk_en_o, timer_clk_en_o, enter_o, i_flag_o, stop_o;
  logic        timer_request_flag_o, timer_irq_mask_o, wait_o, prescaler_clr_o, counter_load_o;
  logic [7:0]  timer_count_i, tcr_wdata_i, ddr_wdata_i, counter_load_val_o;
  logic [1:0]  ddr_sel_i;
  logic [12:0] vector_addr_o, sp_o;
  logic [31:0] ddr_o;
  int          bad_count, checked;
  exc_ctrl #(.EDGE_ONLY(1'b0)) DUT (.sys_clk_i, .sys_rst_i, .reset_pin_n_i, .ext_irq_n_i,
    .instr_done_i, .trap_exec_i, .stop_exec_i, .wait_exec_i, .return_exec_i, .cli_exec_i,
    .sei_exec_i, .push_i, .pull_i, .timer_step_i, .timer_count_i, .tcr_wr_i, .tcr_wdata_i,
    .ddr_wr_i, .ddr_sel_i, .ddr_wdata_i, .core_reset_o, .core_clk_en_o, .timer_clk_en_o,
    .prescaler_clr_o, .counter_load_o, .counter_load_val_o, .enter_o, .vector_addr_o,
    .sp_o, .i_flag_o, .timer_request_flag_o, .timer_irq_mask_o, .ddr_o, .stop_o, .wait_o);
  exc_src_model src (.sys_clk_i, .rst_req_i(rst_req), .irq_pulse_i(irq_pulse),
    .irq_hold_i(irq_hold), .reset_pin_n_o(reset_pin_n_i), .ext_irq_n_o(ext_irq_n_i));
  // ****
  // Tasks, all entered and left at a falling edge
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic stop_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ending instruction: trap, stop, wait qualifiers
  task automatic fin(input logic [2:0] k);
    {instr_done_i, trap_exec_i, stop_exec_i, wait_exec_i} = {1'b1, k};
    cyc(1);
    {instr_done_i, trap_exec_i, stop_exec_i, wait_exec_i} = 4'h0;
    cyc(1);
  endtask
  task automatic await(input logic [12:0] v);
    for (int n = 0; n < 12 && vector_addr_o !== v; n++) cyc(1);
  endtask
  // Five pushes, then the jump must follow within a bounded wait
  task automatic enter(input logic [12:0] v);
    logic [12:0] s0;
    s0 = sp_o;
    chk(vector_addr_o, v);
    push_i = 1'b1;
    cyc(5);
    push_i = 1'b0;
    for (int n = 0; n < 3 && enter_o !== 1'b1; n++) cyc(1);
    chk(enter_o, 1'b1);
    chk(sp_o, s0 - 13'h5);
    cyc(2);
    chk(i_flag_o, 1'b1);
  endtask
  task automatic leave();
    pull_i = 1'b1;
    cyc(5);
    pull_i = 1'b0;
    return_exec_i = 1'b1;
    cyc(1);
    return_exec_i = 1'b0;
  endtask
  task automatic timer_control_reg(input logic [7:0] d);
    tcr_wdata_i = d;
    tcr_wr_i = 1'b1;
    cyc(1);
    tcr_wr_i = 1'b0;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // Whole run is about 2100 cycles
  initial begin
    cyc(6000);
    bad_count++;
    stop_test();
  end
  initial begin
    {instr_done_i, trap_exec_i, stop_exec_i, wait_exec_i, return_exec_i, cli_exec_i} = 6'h0;
    {sei_exec_i, push_i, pull_i, timer_step_i, tcr_wr_i, ddr_wr_i} = 6'h0;
    {rst_req, irq_pulse, irq_hold, ddr_sel_i} = 5'h0;
    {timer_count_i, tcr_wdata_i, ddr_wdata_i} = 24'h800000;
    sys_rst_i = 1'b1;
    cyc(10);
    sys_rst_i = 1'b0;
    cyc(1);
    chk({core_reset_o, i_flag_o, timer_irq_mask_o, timer_request_flag_o, stop_o, wait_o},
        6'h38);
    chk(sp_o, 13'h007f);
    chk(vector_addr_o, 13'h1ffe);
    cyc(1900);
    chk(core_reset_o, 1'b1);
    rst_req = 1'b1;
    cyc(40);
    chk(core_reset_o, 1'b1);
    rst_req = 1'b0;
    cyc(5);
    chk(core_reset_o, 1'b0);
    {ddr_sel_i, ddr_wdata_i, ddr_wr_i} = 11'h4b5;
    cyc(1);
    ddr_wr_i = 1'b0;
    chk(ddr_o, 32'h005a0000);
    rst_req = 1'b1;
    cyc(2);
    rst_req = 1'b0;
    cyc(5);
    chk(ddr_o, 32'h0);
    $display("reset test done");
    irq_pulse = 1'b1;
    cyc(1);
    irq_pulse = 1'b0;
    cyc(4);
    fin(3'h0);
    chk(vector_addr_o, 13'h1ffe);
    cli_exec_i = 1'b1;
    cyc(1);
    cli_exec_i = 1'b0;
    cyc(3);
    chk(vector_addr_o, 13'h1ffe);
    fin(3'h0);
    enter(13'h1ffa);
    leave();
    $display("masked line test done");
    timer_control_reg(8'h00);
    timer_count_i = 8'h01;
    timer_step_i = 1'b1;
    cyc(1);
    timer_step_i = 1'b0;
    irq_pulse = 1'b1;
    cyc(1);
    irq_pulse = 1'b0;
    cyc(4);
    chk(timer_request_flag_o, 1'b1);
    fin(3'h0);
    enter(13'h1ffa);
    leave();
    fin(3'h0);
    enter(13'h1ff8);
    chk(timer_request_flag_o, 1'b1);
    timer_control_reg(8'h40);
    fin(3'h4);
    enter(13'h1ffc);
    leave();
    leave();
    $display("priority test done");
    sei_exec_i = 1'b1;
    cyc(1);
    sei_exec_i = 1'b0;
    timer_control_reg(8'h00);
    fin(3'h1);
    chk({wait_o, i_flag_o, core_clk_en_o, timer_clk_en_o}, 4'h9);
    timer_step_i = 1'b1;
    cyc(1);
    timer_step_i = 1'b0;
    await(13'h1ff6);
    enter(13'h1ff6);
    timer_control_reg(8'h40);
    leave();
    $display("wait test done");
    {instr_done_i, stop_exec_i} = 2'h3;
    cyc(1);
    {instr_done_i, stop_exec_i} = 2'h0;
    chk({prescaler_clr_o, counter_load_o, counter_load_val_o}, 10'h3f0);
    cyc(1);
    chk({stop_o, i_flag_o, timer_irq_mask_o, timer_request_flag_o, core_clk_en_o},
        5'h14);
    irq_hold = 1'b1;
    await(13'h1ffa);
    enter(13'h1ffa);
    chk(stop_o, 1'b0);
    leave();
    fin(3'h0);
    enter(13'h1ffa);
    irq_hold = 1'b0;
    leave();
    $display("stop test done");
    stop_test();
  end
endmodule
